// ==== logic/adc_input_and_soft_mute_control.sv ====
// Purpose: capture input config, polarity and soft mute registers with s-curve mute ramp
// Assumes: i_sample_tick pulses once per sample period; level 0 is infinite attenuation
// Notes: mute scales the programmed level, so both share one attenuation path
// Function
// - per-channel single-ended select, reset differential
// - per-channel polarity invert bit, reset normal
// - per-channel soft mute bit, reset zero
// - unmuted channel applies programmed level normally
// - mute ramps level to infinite along s-curve
// - unmute ramps back to last level
// - mute reuses the attenuation level path
// - active mute overrides any programmed level
// - ramp lasts 2048, 4096 or 8192 samples, set by speed and rate
`timescale 1ns/10ps
`default_nettype none
module adc_input_and_soft_mute_control
	import capture_mute_pkg::*;
#(
	parameter int NCH = CHANNELS,
	parameter int LEVEL_W = 8
) (
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata,
	input wire logic i_sample_tick,
	input wire logic i_attenuation_ramp_speed,
	input wire logic i_capture_rate_mode,
	input wire logic [NCH-1:0][LEVEL_W-1:0] i_atten_level,
	output logic [NCH-1:0] o_single_ended_select,
	output logic [NCH-1:0] o_input_polarity_invert,
	output logic [NCH-1:0][LEVEL_W-1:0] o_applied_level,
	output logic [NCH-1:0] o_mute_settled
);
	// ramp position needs one code more than the step count so a ramp takes all its steps
	localparam int FRAC_W = $clog2(RAMP_STEPS + 1);
	localparam logic [FRAC_W-1:0] FRAC_FULL = FRAC_W'(RAMP_STEPS);
	localparam logic [FRAC_W-1:0] FRAC_NONE = FRAC_W'(MUTE_NONE);
	logic [NCH-1:0] capture_soft_mute_bit;
	logic [NCH-1:0][FRAC_W-1:0] frac;
	logic [5:0] tick_cnt;
	logic [1:0] cfg;
	logic [NCH-1:0] next_se, next_pol, next_mute, next_settled;
	logic [NCH-1:0][FRAC_W-1:0] next_frac;
	logic [NCH-1:0][LEVEL_W-1:0] next_level;
	logic [7:0] next_rdata;
	logic [5:0] next_tick_cnt;
	logic [5:0] limit;
	logic step;

	// samples per ramp step: 8, 16 or 32 scaled by speed and rate (speed and rate each double it)
	function automatic logic [5:0] step_limit(input logic speed, input logic dual);
		int n;
		n = SAMPLES_PER_STEP << (int'(speed) + int'(dual));
		return n[5:0];
	endfunction : step_limit

	// smoothstep of the remaining gain fraction, RAMP_STEPS means full gain
	function automatic logic [FRAC_W-1:0] s_curve(input logic [FRAC_W-1:0] f);
		int x;
		int s;
		x = RAMP_STEPS - int'(f);
		s = (3 * x * x * RAMP_STEPS - 2 * x * x * x) / (RAMP_STEPS * RAMP_STEPS);
		return s[FRAC_W-1:0];
	endfunction : s_curve

	function automatic logic [5:0] reg_read(input logic [7:0] a, input logic [5:0] se,
		input logic [5:0] pol, input logic [5:0] mute);
		case (a)
			ADDR_INPUT_CONFIG: return se;
			ADDR_INPUT_PHASE: return pol;
			ADDR_SOFT_MUTE: return mute;
			default: return REG_RESET;
		endcase
	endfunction : reg_read

	always_comb begin
		limit = step_limit(i_attenuation_ramp_speed, i_capture_rate_mode);
		next_se = o_single_ended_select;
		next_pol = o_input_polarity_invert;
		next_mute = capture_soft_mute_bit;
		next_rdata = o_rdata;
		if (i_wr_en && i_addr == ADDR_INPUT_CONFIG) begin
			next_se = i_wdata[FIELD_LSB +: FIELD_WIDTH];
		end
		if (i_wr_en && i_addr == ADDR_INPUT_PHASE) begin
			next_pol = i_wdata[FIELD_LSB +: FIELD_WIDTH];
		end
		if (i_wr_en && i_addr == ADDR_SOFT_MUTE) begin
			next_mute = i_wdata[FIELD_LSB +: FIELD_WIDTH];
		end
		if (i_rd_en) begin
			next_rdata = {2'b00, reg_read(i_addr, o_single_ended_select,
				o_input_polarity_invert, capture_soft_mute_bit)};
		end
	end

	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_single_ended_select <= REG_RESET;
			o_input_polarity_invert <= REG_RESET;
			capture_soft_mute_bit <= REG_RESET;
			o_rdata <= RDATA_RESET;
		end else begin
			o_single_ended_select <= next_se;
			o_input_polarity_invert <= next_pol;
			capture_soft_mute_bit <= next_mute;
			o_rdata <= next_rdata;
		end
	end

	always_comb begin
		step = 1'b0;
		next_tick_cnt = tick_cnt;
		// step period from speed and rate, restarted on change
		if (cfg != {i_attenuation_ramp_speed, i_capture_rate_mode}) begin
			next_tick_cnt = '0;
		end else if (i_sample_tick) begin
			if (tick_cnt >= limit - 6'd1) begin
				step = 1'b1;
				next_tick_cnt = '0;
			end else begin
				next_tick_cnt = tick_cnt + 6'd1;
			end
		end
		for (int c = 0; c < NCH; c++) begin
			next_frac[c] = frac[c];
			if (step && capture_soft_mute_bit[c] && frac[c] != FRAC_FULL) begin
				next_frac[c] = frac[c] + FRAC_W'(1);
			end
			// release walks back to programmed level
			if (step && !capture_soft_mute_bit[c] && frac[c] != FRAC_NONE) begin
				next_frac[c] = frac[c] - FRAC_W'(1);
			end
			if (frac[c] == FRAC_NONE) begin
				next_level[c] = i_atten_level[c];
			end else begin
				next_level[c] = LEVEL_W'((int'(i_atten_level[c]) * int'(s_curve(frac[c])))
					/ RAMP_STEPS);
			end
			next_settled[c] = (frac[c] == FRAC_FULL);
		end
	end

	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			frac <= '0;
			tick_cnt <= '0;
			cfg <= 2'b00;
			o_applied_level <= '0;
			o_mute_settled <= '0;
		end else begin
			frac <= next_frac;
			tick_cnt <= next_tick_cnt;
			cfg <= {i_attenuation_ramp_speed, i_capture_rate_mode};
			o_applied_level <= next_level;
			o_mute_settled <= next_settled;
		end
	end

	// helper: sample ticks seen since the last step under stable settings
	logic [5:0] ticks_seen;
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ticks_seen <= '0;
		end else if (step || cfg != {i_attenuation_ramp_speed, i_capture_rate_mode}) begin
			ticks_seen <= '0;
		end else if (i_sample_tick) begin
			ticks_seen <= ticks_seen + 6'd1;
		end
	end

	sequence wr_to(logic [7:0] a);
		i_wr_en && i_addr == a;
	endsequence

	chk_config_write: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		wr_to(ADDR_INPUT_CONFIG) |=> o_single_ended_select == $past(i_wdata[5:0]))
		else $error("input config write not stored");
	chk_phase_write: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		wr_to(ADDR_INPUT_PHASE) |=> o_input_polarity_invert == $past(i_wdata[5:0]))
		else $error("input phase write not stored");
	chk_mute_write: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		wr_to(ADDR_SOFT_MUTE) ##1 !i_wr_en ##1 i_rd_en && i_addr == ADDR_SOFT_MUTE
		|=> o_rdata[5:0] == $past(i_wdata[5:0], 3))
		else $error("soft mute readback wrong");
	chk_unmuted_level: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		frac[0] == FRAC_NONE |=> o_applied_level[0] == $past(i_atten_level[0]))
		else $error("unmuted level not passed through");
	chk_mute_ramp_down: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		step && capture_soft_mute_bit[0] && frac[0] != FRAC_FULL
		|=> frac[0] == $past(frac[0]) + FRAC_W'(1))
		else $error("mute ramp did not advance");
	chk_full_mute_zero: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		frac[0] == FRAC_FULL |=> o_mute_settled[0] && o_applied_level[0] == '0)
		else $error("ramp end not fully muted");
	chk_unmute_ramp_up: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		step && !capture_soft_mute_bit[0] && frac[0] != FRAC_NONE
		|=> frac[0] == $past(frac[0]) - FRAC_W'(1))
		else $error("release ramp did not advance");
	chk_level_bounded: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		o_applied_level[0] <= $past(i_atten_level[0]))
		else $error("applied level above programmed level");
	chk_ramp_hold: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		!step |=> $stable(frac))
		else $error("ramp moved between steps");
	chk_mute_override: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		frac[0] == FRAC_FULL && capture_soft_mute_bit[0] && $changed(i_atten_level[0])
		|=> o_applied_level[0] == '0)
		else $error("level write lifted muted output");
	chk_step_period: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		step |-> int'(ticks_seen) + 1 == ((RAMP_BASE_SAMPLES / RAMP_STEPS)
		<< (int'(i_attenuation_ramp_speed) + int'(i_capture_rate_mode))))
		else $error("ramp step period wrong");
	chk_upper_zero: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		i_rd_en |=> o_rdata[7:6] == 2'b00)
		else $error("upper read bits not zero");
endmodule : adc_input_and_soft_mute_control
`default_nettype wire

// ==== logic/capture_mute_pkg.sv ====
// Purpose: shared constants for the capture input and soft mute register bank
// Assumes: eight-bit register addresses, six capture channels
// Notes: ramp is split into a fixed number of equal steps
package capture_mute_pkg;
	localparam int CHANNELS = 6;
	localparam int FIELD_LSB = 0;
	localparam int FIELD_WIDTH = 6;
	localparam logic [7:0] ADDR_INPUT_CONFIG = 8'h53;
	localparam logic [7:0] ADDR_INPUT_PHASE = 8'h54;
	localparam logic [7:0] ADDR_SOFT_MUTE = 8'h55;
	localparam logic [5:0] REG_RESET = 6'h00;
	localparam logic [7:0] RDATA_RESET = 8'h00;
	localparam int RAMP_BASE_SAMPLES = 2048;
	localparam int RAMP_STEPS = 256;
	localparam int SAMPLES_PER_STEP = RAMP_BASE_SAMPLES / RAMP_STEPS;
	localparam logic [7:0] MUTE_FULL = 8'hff;
	localparam logic [7:0] MUTE_NONE = 8'h00;
endpackage : capture_mute_pkg

// ==== test/host_ctrl_model.sv ====
// Purpose: host side of the byte register port
// Assumes: strobes sampled on rising edge, read data valid one cycle later
// Notes: one access at a time, signals change only just after an edge
`timescale 1ns/10ps
`default_nettype none
module host_ctrl_model (
	input wire logic i_mclk,
	input wire logic [7:0] i_rdata,
	output logic o_wr_en,
	output logic o_rd_en,
	output logic [7:0] o_addr,
	output logic [7:0] o_wdata
);
	initial begin
		o_wr_en = 1'b0;
		o_rd_en = 1'b0;
		o_addr = 8'h00;
		o_wdata = 8'h00;
	end
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		o_wr_en <= 1'b1;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_mclk);
		o_wr_en <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_mclk);
		o_rd_en <= 1'b1;
		o_addr <= a;
		@(posedge i_mclk);
		o_rd_en <= 1'b0;
		// registered read data stands from the read edge until the next read
		@(posedge i_mclk);
		d = i_rdata;
	endtask : rd
endmodule : host_ctrl_model
`default_nettype wire

// ==== test/adc_input_and_soft_mute_control_bench.sv ====
// Purpose: self-checking bench for the capture config and soft mute bank
// Assumes: sample tick every second clock
// Notes: ramp times checked with a small tolerance for prescaler phase
`timescale 1ns/10ps
`default_nettype none
module adc_input_and_soft_mute_control_bench;
	import capture_mute_pkg::*;
	logic i_mclk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic i_sample_tick = 1'b0;
	logic speed = 1'b0;
	logic rate = 1'b0;
	logic [CHANNELS-1:0][7:0] level = '0;
	logic wr_en, rd_en;
	logic [7:0] addr, wdata, rdata, rd_val, wv;
	logic [CHANNELS-1:0] se, pol, settled;
	logic [CHANNELS-1:0][7:0] applied;
	int fails = 0;
	int n_checks = 0;
	int model[3];
	int k, t, c, e;
	always #5 i_mclk = ~i_mclk;
	always @(posedge i_mclk) i_sample_tick <= ~i_sample_tick;
	adc_input_and_soft_mute_control #(.NCH(CHANNELS), .LEVEL_W(8)) DUT (.i_mclk(i_mclk),
		.i_sys_rst(i_sys_rst), .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr),
		.i_wdata(wdata), .o_rdata(rdata), .i_sample_tick(i_sample_tick),
		.i_attenuation_ramp_speed(speed), .i_capture_rate_mode(rate),
		.i_atten_level(level), .o_single_ended_select(se), .o_input_polarity_invert(pol),
		.o_applied_level(applied), .o_mute_settled(settled));
	host_ctrl_model host (.i_mclk(i_mclk), .i_rdata(rdata), .o_wr_en(wr_en),
		.o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata));
	task check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task finish_test;
		if (fails == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : finish_test
	// writes the mute byte and counts cycles until channel 0 ends its ramp
	task ramp(input logic [7:0] mv);
		host.wr(ADDR_SOFT_MUTE, mv);
		t = 0;
		while ((mv[0] ? settled[0] !== 1'b1 : applied[0] !== level[0]) && t < 20000) begin
			@(posedge i_mclk);
			t++;
		end
		if (t >= 20000) begin
			fails++;
			finish_test();
		end
	endtask : ramp
	initial begin
		void'($urandom(32'h57e70307));
		repeat (4) @(posedge i_mclk);
		i_sys_rst <= 1'b0;
		level <= 48'({$urandom(), $urandom()} | 64'h0101_0101_0101);
		for (k = 0; k < 3; k++) begin
			host.rd(ADDR_INPUT_CONFIG + 8'(k), rd_val);
			check("reset_value", rd_val, 8'h00);
		end
		for (c = 0; c < 9; c++) begin
			k = c % 3;
			wv = 8'($urandom());
			host.wr(ADDR_INPUT_CONFIG + 8'(k), wv);
			model[k] = wv & 8'h3f;
			host.rd(ADDR_INPUT_CONFIG + 8'(k), rd_val);
			check("reg_readback", rd_val, 8'(model[k]));
		end
		check("single_ended", {2'b00, se}, 8'(model[0]));
		check("polarity", {2'b00, pol}, 8'(model[1]));
		host.wr(8'h56, 8'hff);
		host.rd(8'h56, rd_val);
		check("unmapped", rd_val, 8'h00);
		host.wr(ADDR_SOFT_MUTE, 8'h00);
		repeat (16500) @(posedge i_mclk);
		for (c = 0; c < CHANNELS; c++) check("unmuted_level", applied[c], level[c]);
		for (k = 0; k < 4; k++) begin
			speed <= k[0];
			rate <= k[1];
			e = (2 * RAMP_BASE_SAMPLES) << (int'(k[0]) + int'(k[1]));
			ramp(8'h01);
			check("mute_time", 8'(t > e - 64 && t < e + 64), 8'h01);
			check("muted_level", applied[0], 8'h00);
			check("settled", {2'b00, settled}, 8'h01);
			check("other_channel", applied[1], level[1]);
			level[0] <= 8'(level[0] + 8'h35) | 8'h01;
			repeat (8) @(posedge i_mclk);
			check("mute_priority", applied[0], 8'h00);
			ramp(8'h00);
			check("unmute_time", 8'(t > e - 64 && t < e + 64), 8'h01);
			check("released", {2'b00, settled}, 8'h00);
		end
		finish_test();
	end
endmodule : adc_input_and_soft_mute_control_bench
`default_nettype wire
